// ---- hdl/cfgword_pkg.sv ----
package cfgword_pkg;
    typedef enum logic [1:0] {
        MODE_OFF, MODE_SOFT, MODE_RUN_ONLY, MODE_ALWAYS
    } enable_mode_t;
    typedef enum logic [1:0] {
        OSC_INTERNAL, OSC_EXT_LOW, OSC_EXT_MEDIUM, OSC_EXT_HIGH
    } osc_source_t;
    typedef enum logic [1:0] {
        RD_IDLE, RD_DISCARD, RD_FETCH
    } read_state_t;
endpackage

// ---- hdl/cfgword_regs.svh ----
`ifndef CFGWORD_REGS_SVH
`define CFGWORD_REGS_SVH

// Register byte offsets on the AXI4-Lite bus
`define OFS_CONFIG_WORD      8'h00
`define OFS_PM_ADDR_LOW      8'h04
`define OFS_PM_ADDR_HIGH     8'h08
`define OFS_PM_DATA_LOW      8'h0c
`define OFS_PM_DATA_HIGH     8'h10
`define OFS_PM_CONTROL       8'h14
`define OFS_SOFT_ENABLES     8'h18
`define OFS_STATUS           8'h1c
`define OFS_ERASE_KEY        8'h20

// Configuration word fields
`define CFG_WIDTH            14
`define CFG_BLANK            14'h3fff
`define CFG_UNUSED_MASK      14'h3104
`define CFG_CLK_OUT_BIT      11
`define CFG_BROWN_HI         10
`define CFG_BROWN_LO         9
`define CFG_PROT_BIT         7
`define CFG_RSTPIN_BIT       6
`define CFG_PWRUP_BIT        5
`define CFG_WDOG_HI          4
`define CFG_WDOG_LO          3
`define CFG_OSC_HI           1
`define CFG_OSC_LO           0

// Program memory control bits
`define CTL_READ_BIT         0
`define CTL_SPACE_BIT        6
`define CTL_LOWV_BIT         7
`define ADDR_HIGH_WIDTH      7
`define ERASE_KEY_VALUE      32'h0000_e5a5

// Soft enable bits
`define SOFT_BROWN_BIT       0
`define SOFT_WDOG_BIT        1
`define SOFT_PULLUP_BIT      2

// AXI responses
`define RESP_OKAY            2'b00
`define RESP_SLVERR          2'b10

`endif

// ---- hdl/config_decode.sv ----
`include "cfgword_regs.svh"

module config_decode
    import cfgword_pkg::*;
(
    // Clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // Raw fuse word and sleep/soft inputs
    input  wire logic [`CFG_WIDTH-1:0]   cfg_word,
    input  wire logic                    low_voltage_program,
    input  wire logic                    in_sleep,
    input  wire logic                    soft_brownout_enable,
    input  wire logic                    soft_watchdog_enable,
    input  wire logic                    reset_pin_pullup,
    // Decoded settings
    output logic                         clock_out_active,
    output logic                         brownout_active,
    output logic                         watchdog_active,
    output cfgword_pkg::enable_mode_t    brownout_reset_mode,
    output cfgword_pkg::enable_mode_t    watchdog_mode,
    output cfgword_pkg::osc_source_t     oscillator_select,
    output logic                         code_protect_on,
    output logic                         powerup_timer_on,
    output logic                         ext_reset_enabled,
    output logic                         pullup_on
);
    import cfgword_pkg::*;

    wire enable_mode_t brown_w = enable_mode_t'(cfg_word[`CFG_BROWN_HI:`CFG_BROWN_LO]);
    wire enable_mode_t wdog_w  = enable_mode_t'(cfg_word[`CFG_WDOG_HI:`CFG_WDOG_LO]);
    wire osc_source_t  osc_w = osc_source_t'(cfg_word[`CFG_OSC_HI:`CFG_OSC_LO]);
    wire rst_pin_w = low_voltage_program | cfg_word[`CFG_RSTPIN_BIT]; // R6 R7

    function automatic logic mode_on(enable_mode_t m, logic sleep_i, logic soft_i);
        case (m)
            MODE_ALWAYS:   mode_on = 1'b1;
            MODE_RUN_ONLY: mode_on = ~sleep_i;
            MODE_SOFT:     mode_on = soft_i;
            default:       mode_on = 1'b0;
        endcase
    endfunction

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clock_out_active    <= 1'b0;
            brownout_active     <= 1'b0;
            watchdog_active     <= 1'b0;
            brownout_reset_mode <= MODE_OFF;
            watchdog_mode       <= MODE_OFF;
            oscillator_select   <= OSC_INTERNAL;
            code_protect_on     <= 1'b0;
            powerup_timer_on    <= 1'b0;
            ext_reset_enabled   <= 1'b0;
            pullup_on           <= 1'b0;
        end else begin
            clock_out_active    <= ~cfg_word[`CFG_CLK_OUT_BIT]; // R2
            brownout_reset_mode <= brown_w; // R3
            brownout_active     <= mode_on(brown_w, in_sleep, soft_brownout_enable); // R3
            watchdog_mode       <= wdog_w; // R10
            watchdog_active     <= mode_on(wdog_w, in_sleep, soft_watchdog_enable); // R10
            oscillator_select   <= osc_w; // R11
            code_protect_on     <= ~cfg_word[`CFG_PROT_BIT]; // R4
            powerup_timer_on    <= ~cfg_word[`CFG_PWRUP_BIT]; // R8 R9
            ext_reset_enabled   <= rst_pin_w; // R7
            pullup_on           <= rst_pin_w | reset_pin_pullup; // R7
        end
    end
endmodule // config_decode

// ---- hdl/config_word_and_progmem_read.sv ----
// How it works
// R1 - Unused configuration bits always read one
// R2 - Clock-out fuse zero drives clock output
// R3 - Brown-out field selects always/run/soft/off
// R4 - Code-protect fuse zero enables protection
// R5 - Protection clears only by bulk erase
// R6 - Low-voltage programming ignores reset-pin fuse
// R7 - Reset-pin fuse picks reset or input
// R8 - Power-up timer fuse zero enables timer
// R9 - Brown-out and power-up timer decode independently
// R10 - Watchdog field selects always/run/soft/off
// R11 - Oscillator field selects external or internal
// R12 - Blank or erased word reads all ones
// R13 - Requester loads address, clears space, strobes
// R14 - Second cycle fetches; that slot discarded
// R15 - Fetched word lands in data pair next
// R16 - Data pair held until reread or write
// R17 - Requester places two no-ops after strobe
// R18 - Fields latched at reset, held stable
`include "cfgword_regs.svh"

module config_word_and_progmem_read
    import cfgword_pkg::*;
(
    // Clock and reset
    input  wire logic                    aclk,
    input  wire logic                    aresetn,
    // AXI4-Lite write address
    input  wire logic [7:0]              s_axi_awaddr,
    input  wire logic                    s_axi_awvalid,
    output logic                         s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0]             s_axi_wdata,
    input  wire logic [3:0]              s_axi_wstrb,
    input  wire logic                    s_axi_wvalid,
    output logic                         s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]                   s_axi_bresp,
    output logic                         s_axi_bvalid,
    input  wire logic                    s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]              s_axi_araddr,
    input  wire logic                    s_axi_arvalid,
    output logic                         s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]                  s_axi_rdata,
    output logic [1:0]                   s_axi_rresp,
    output logic                         s_axi_rvalid,
    input  wire logic                    s_axi_rready,
    // Fuse array and program memory
    input  wire logic [`CFG_WIDTH-1:0]   fuse_word,
    output logic [14:0]                  progmem_addr,
    input  wire logic [13:0]             progmem_rdata,
    input  wire logic [13:0]             config_space_rdata,
    // Core side
    input  wire logic                    in_sleep,
    output logic                         core_discard,
    output logic                         read_busy,
    // Decoded settings
    output logic                         clock_out_active,
    output logic                         brownout_active,
    output logic                         watchdog_active,
    output cfgword_pkg::enable_mode_t    brownout_reset_mode,
    output cfgword_pkg::enable_mode_t    watchdog_mode,
    output cfgword_pkg::osc_source_t     oscillator_select,
    output logic                         code_protect_on,
    output logic                         powerup_timer_on,
    output logic                         ext_reset_enabled,
    output logic                         pullup_on
);
    import cfgword_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Registers
    logic [`CFG_WIDTH-1:0]       cfg_r;
    logic                        cfg_loaded_r;
    logic                        protect_latch_r;
    logic [7:0]                  addr_low_r;
    logic [`ADDR_HIGH_WIDTH-1:0] addr_high_r;
    logic [7:0]                  data_low_r;
    logic [5:0]                  data_high_r;
    logic                        space_r;
    logic                        lowv_r;
    logic                        soft_brown_r;
    logic                        soft_wdog_r;
    logic                        soft_pull_r;
    read_state_t                 rd_state_r;
    logic [31:0]                 wdata_r;
    logic [3:0]                  wstrb_r;
    logic [7:0]                  waddr_r;
    logic                        aw_held_r;
    logic                        w_held_r;

    ////////////////////////////////////////////////////////////////////////
    // Write channel: address and data accepted in either order
    wire aw_take    = s_axi_awvalid & s_axi_awready;
    wire w_take     = s_axi_wvalid & s_axi_wready;
    wire aw_have    = aw_held_r | aw_take;
    wire w_have     = w_held_r | w_take;
    wire [7:0]  wa  = aw_held_r ? waddr_r : s_axi_awaddr;
    wire [31:0] wd  = w_held_r ? wdata_r : s_axi_wdata;
    // Strobes travel with the data beat they were offered with
    wire [3:0]  ws  = w_held_r ? wstrb_r : s_axi_wstrb;
    wire wr_fire    = aw_have & w_have & ~s_axi_bvalid;
    wire wr_low     = wr_fire & ws[0];
    wire wr_alow    = wr_low & (wa == `OFS_PM_ADDR_LOW);
    wire wr_ahigh   = wr_low & (wa == `OFS_PM_ADDR_HIGH);
    wire wr_dlow    = wr_low & (wa == `OFS_PM_DATA_LOW);
    wire wr_dhigh   = wr_low & (wa == `OFS_PM_DATA_HIGH);
    wire wr_ctl     = wr_low & (wa == `OFS_PM_CONTROL);
    wire wr_soft    = wr_low & (wa == `OFS_SOFT_ENABLES);
    wire wr_erase   = wr_fire & (wa == `OFS_ERASE_KEY) & (&ws)
                      & (wd == `ERASE_KEY_VALUE);
    wire wa_mapped  = (wa == `OFS_CONFIG_WORD) | (wa == `OFS_PM_ADDR_LOW)
                    | (wa == `OFS_PM_ADDR_HIGH) | (wa == `OFS_PM_DATA_LOW)
                    | (wa == `OFS_PM_DATA_HIGH) | (wa == `OFS_PM_CONTROL)
                    | (wa == `OFS_SOFT_ENABLES) | (wa == `OFS_STATUS)
                    | (wa == `OFS_ERASE_KEY);

    ////////////////////////////////////////////////////////////////////////
    // Read strobe sequencing
    wire rd_start   = wr_ctl & wd[`CTL_READ_BIT] & (rd_state_r == RD_IDLE); // R13
    wire fetch_now  = (rd_state_r == RD_FETCH);
    wire [13:0] fetched = space_r ? config_space_rdata : progmem_rdata;
    wire [6:0]  ctl_view = {space_r, 5'h00, (rd_state_r != RD_IDLE)};

    read_state_t rd_state_nxt;
    always_comb begin
        case (rd_state_r)
            RD_IDLE:    rd_state_nxt = rd_start ? RD_DISCARD : RD_IDLE;
            RD_DISCARD: rd_state_nxt = RD_FETCH;
            RD_FETCH:   rd_state_nxt = RD_IDLE;
            default:    rd_state_nxt = RD_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Configuration word readback with unused positions forced high
    wire [`CFG_WIDTH-1:0] cfg_view = cfg_r | `CFG_UNUSED_MASK; // R1

    ////////////////////////////////////////////////////////////////////////
    // Read channel decode
    logic [31:0] rd_mux;
    logic        rd_ok;
    always_comb begin
        rd_ok = 1'b1;
        case (s_axi_araddr)
            `OFS_CONFIG_WORD:  rd_mux = {18'h0, cfg_view};
            `OFS_PM_ADDR_LOW:  rd_mux = {24'h0, addr_low_r};
            `OFS_PM_ADDR_HIGH: rd_mux = {25'h0, addr_high_r};
            `OFS_PM_DATA_LOW:  rd_mux = {24'h0, data_low_r};
            `OFS_PM_DATA_HIGH: rd_mux = {26'h0, data_high_r};
            `OFS_PM_CONTROL:   rd_mux = {24'h0, lowv_r, ctl_view};
            `OFS_SOFT_ENABLES: rd_mux = {29'h0, soft_pull_r, soft_wdog_r, soft_brown_r};
            `OFS_STATUS:       rd_mux = {29'h0, cfg_loaded_r, protect_latch_r, read_busy};
            `OFS_ERASE_KEY:    rd_mux = 32'h0;
            default: begin
                rd_mux = 32'h0;
                rd_ok  = 1'b0;
            end
        endcase
    end
    wire ar_take = s_axi_arvalid & s_axi_arready;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `RESP_OKAY;
            aw_held_r     <= 1'b0;
            w_held_r      <= 1'b0;
            waddr_r       <= 8'h00;
            wdata_r       <= 32'h0;
            wstrb_r       <= 4'h0;
        end else begin
            s_axi_awready <= ~aw_have & ~s_axi_bvalid;
            s_axi_wready  <= ~w_have & ~s_axi_bvalid;
            if (aw_take)
                waddr_r <= s_axi_awaddr;
            if (w_take) begin
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
            end
            aw_held_r <= aw_have & ~wr_fire;
            w_held_r  <= w_have & ~wr_fire;
            if (wr_fire) begin
                s_axi_awready <= 1'b0;
                s_axi_wready  <= 1'b0;
                s_axi_bvalid  <= 1'b1;
                s_axi_bresp   <= wa_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_bvalid & s_axi_bready) begin
                s_axi_bvalid  <= 1'b0;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `RESP_OKAY;
        end else begin
            s_axi_arready <= ~s_axi_rvalid & ~ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_mux;
                s_axi_rresp  <= rd_ok ? `RESP_OKAY : `RESP_SLVERR;
            end else if (s_axi_rvalid & s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fuse capture and code protection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r           <= `CFG_BLANK; // R12
            cfg_loaded_r    <= 1'b0;
            protect_latch_r <= 1'b0;
        end else begin
            if (wr_erase) begin
                cfg_r           <= `CFG_BLANK; // R12
                protect_latch_r <= 1'b0; // R5
            end else begin
                if (!cfg_loaded_r)
                    cfg_r <= fuse_word; // R18
                if (!cfg_r[`CFG_PROT_BIT] && cfg_loaded_r)
                    protect_latch_r <= 1'b1; // R5
            end
            cfg_loaded_r <= 1'b1; // R18
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Address, control and data registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            addr_low_r  <= 8'h00;
            addr_high_r <= '0;
            space_r      <= 1'b0;
            lowv_r       <= 1'b1;
            soft_brown_r <= 1'b0;
            soft_wdog_r  <= 1'b0;
            soft_pull_r <= 1'b0;
            rd_state_r  <= RD_IDLE;
        end else begin
            if (wr_alow)
                addr_low_r <= wd[7:0];
            if (wr_ahigh)
                addr_high_r <= wd[`ADDR_HIGH_WIDTH-1:0];
            if (wr_ctl) begin
                space_r <= wd[`CTL_SPACE_BIT];
                lowv_r  <= wd[`CTL_LOWV_BIT];
            end
            if (wr_soft) begin
                soft_brown_r <= wd[`SOFT_BROWN_BIT];
                soft_wdog_r  <= wd[`SOFT_WDOG_BIT];
                soft_pull_r <= wd[`SOFT_PULLUP_BIT];
            end
            rd_state_r <= rd_state_nxt; // R14
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            data_low_r  <= 8'h00;
            data_high_r <= 6'h00;
        end else if (fetch_now) begin
            data_low_r  <= fetched[7:0]; // R15
            data_high_r <= fetched[13:8]; // R15
        end else begin
            if (wr_dlow)
                data_low_r <= wd[7:0]; // R16
            if (wr_dhigh)
                data_high_r <= wd[5:0]; // R16
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            progmem_addr <= 15'h0000;
            core_discard <= 1'b0;
            read_busy    <= 1'b0;
        end else begin
            progmem_addr <= {addr_high_r, addr_low_r};
            core_discard <= (rd_state_nxt == RD_FETCH); // R14 R17
            read_busy    <= (rd_state_nxt != RD_IDLE);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fuse decode
    config_decode u_decode (
        .aclk                 (aclk),
        .aresetn              (aresetn),
        .cfg_word             (cfg_r),
        .low_voltage_program  (lowv_r),
        .in_sleep             (in_sleep),
        .soft_brownout_enable (soft_brown_r),
        .soft_watchdog_enable (soft_wdog_r),
        .reset_pin_pullup     (soft_pull_r),
        .clock_out_active     (clock_out_active),
        .brownout_active      (brownout_active),
        .watchdog_active      (watchdog_active),
        .brownout_reset_mode  (brownout_reset_mode),
        .watchdog_mode        (watchdog_mode),
        .oscillator_select    (oscillator_select),
        .code_protect_on      (code_protect_on),
        .powerup_timer_on     (powerup_timer_on),
        .ext_reset_enabled    (ext_reset_enabled),
        .pullup_on            (pullup_on)
    );

    ////////////////////////////////////////////////////////////////////////
    // Checks
    unused_ones_a: assert property (@(posedge aclk) disable iff (!aresetn) // R1
        ar_take && s_axi_araddr == `OFS_CONFIG_WORD |=>
            (s_axi_rdata[`CFG_WIDTH-1:0] & `CFG_UNUSED_MASK) == `CFG_UNUSED_MASK)
        else $error("unused config bits not one");
    clk_out_a: assert property (@(posedge aclk) disable iff (!aresetn) // R2
        cfg_loaded_r && $stable(cfg_r) |=> clock_out_active == ~$past(cfg_r[`CFG_CLK_OUT_BIT]))
        else $error("clock out decode wrong");
    brown_always_a: assert property (@(posedge aclk) disable iff (!aresetn) // R3
        cfg_r[`CFG_BROWN_HI:`CFG_BROWN_LO] == 2'b11 |=> brownout_active)
        else $error("brown-out not always on");
    protect_decode_a: assert property (@(posedge aclk) disable iff (!aresetn) // R4
        !cfg_r[`CFG_PROT_BIT] |=> code_protect_on)
        else $error("protection not decoded");
    protect_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn) // R5
        protect_latch_r && !wr_erase |=> protect_latch_r)
        else $error("protection dropped without erase");
    lowv_ignore_a: assert property (@(posedge aclk) disable iff (!aresetn) // R6
        lowv_r |=> ext_reset_enabled)
        else $error("reset pin fuse not ignored");
    pwrup_decode_a: assert property (@(posedge aclk) disable iff (!aresetn) // R8
        cfg_r[`CFG_PWRUP_BIT] |=> !powerup_timer_on)
        else $error("power-up timer decode wrong");
    wdog_off_a: assert property (@(posedge aclk) disable iff (!aresetn) // R10
        cfg_r[`CFG_WDOG_HI:`CFG_WDOG_LO] == 2'b00 |=> !watchdog_active)
        else $error("watchdog not off");
    fetch_timing_a: assert property (@(posedge aclk) disable iff (!aresetn) // R14
        rd_start |=> read_busy && !core_discard ##1 core_discard && fetch_now ##1 !read_busy)
        else $error("fetch slot timing wrong");
    data_land_a: assert property (@(posedge aclk) disable iff (!aresetn) // R15
        fetch_now |=> data_low_r == $past(fetched[7:0]))
        else $error("fetched word missing");
    data_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // R16
        !fetch_now && !wr_dlow |=> $stable(data_low_r))
        else $error("data register changed");
    cfg_stable_a: assert property (@(posedge aclk) disable iff (!aresetn) // R18
        cfg_loaded_r && !wr_erase |=> $stable(cfg_r))
        else $error("config word changed while running");

    read_seen_c: cover property (@(posedge aclk) disable iff (!aresetn) rd_start ##2 fetch_now);
    erase_seen_c: cover property (@(posedge aclk) disable iff (!aresetn) wr_erase);
    slverr_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
        s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule // config_word_and_progmem_read

// ---- verif/progmem_model.sv ----
////////////////////////////////////////////////////////////////////////////////
// Program memory and config space behind the read path
module progmem_model (
    // Address from the block
    input  wire logic [14:0] progmem_addr,
    // Words back, combinational on the address
    output logic      [13:0] progmem_rdata,
    output logic      [13:0] config_space_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    assign progmem_rdata      = progmem_addr[13:0] ^ {progmem_addr[14], 13'h1c3b};
    assign config_space_rdata = progmem_addr[13:0] ^ 14'h2aa5;
endmodule // progmem_model

// ---- verif/tb.sv ----
`include "cfgword_regs.svh"
////////////////////////////////////////////////////////////////////////////////
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cfgword_pkg::*;
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected t=%0t got=%h exp=%h", $time, a, e); end end
    logic         aclk = 0, aresetn = 0, in_sleep = 0;
    logic [7:0]   s_axi_awaddr = 0, s_axi_araddr = 0;
    logic         s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic         s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0]  s_axi_wdata = 0, s_axi_rdata;
    logic [3:0]   s_axi_wstrb = 4'hf;
    logic [13:0]  fuse_word = 0, progmem_rdata, config_space_rdata;
    logic         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]   s_axi_bresp, s_axi_rresp;
    logic [14:0]  progmem_addr;
    logic         core_discard, read_busy, clock_out_active, brownout_active;
    logic         watchdog_active, code_protect_on, powerup_timer_on;
    logic         ext_reset_enabled, pullup_on;
    enable_mode_t brownout_reset_mode, watchdog_mode;
    osc_source_t  oscillator_select;
    int           error_cnt = 0, compares = 0, seed = 32'h1a49, disc = 0;

    config_word_and_progmem_read config_word_and_progmem_read_i (.*);
    progmem_model progmem_model_i (.progmem_addr(progmem_addr),
        .progmem_rdata(progmem_rdata), .config_space_rdata(config_space_rdata));

    initial begin
        forever #2 aclk = ~aclk;
    end
    // Discard slots seen so far
    always @(posedge aclk) begin
        disc += core_discard;
    end

    function automatic logic [13:0] pm_word(input logic [14:0] a, input logic cfg);
        return cfg ? a[13:0] ^ 14'h2aa5 : a[13:0] ^ {a[14], 13'h1c3b};
    endfunction

    // Effective enable of a two-bit mode field: always, run only, soft, off
    function automatic logic mode_exp(input logic [1:0] m, input logic s, input logic sw);
        return (m == 2'b11) | ((m == 2'b10) & ~s) | ((m == 2'b01) & sw);
    endfunction

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Ready sampled mid-cycle, so the handshake at the next edge is known
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ah, wh, bh;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge aclk);
            ah = s_axi_awready;
            wh = s_axi_wready;
            bh = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
            if (ah) s_axi_awvalid <= 1'b0;
            if (wh) s_axi_wvalid <= 1'b0;
            // Response taken; bready stays up for the next write
            if (bh)
                return;
        end
        error_cnt++;
        wrap_up();
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ah, vh;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            @(negedge aclk);
            ah = s_axi_arready;
            vh = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ah) s_axi_arvalid <= 1'b0;
            // Data taken; rready stays up for the next read
            if (vh)
                return;
        end
        error_cnt++;
        wrap_up();
    endtask

    initial begin
        logic [13:0] f, e;
        logic [14:0] pa;
        logic [31:0] d;
        logic [1:0]  r;
        int          c0;
        for (int i = 0; i < 4; i++) begin
            f = 14'($random(seed));
            f[10:9] = i[1:0];
            f[4:3] = ~i[1:0];
            f[1:0] = i[1:0];
            f[7] = (i != 3);
            fuse_word <= f;
            in_sleep <= i[0];
            aresetn <= 1'b0;
            repeat (6) @(posedge aclk);
            aresetn <= 1'b1;
            repeat (3) @(posedge aclk);
            rd(`OFS_CONFIG_WORD, d, r);
            `CHK(d, {18'h0, f | `CFG_UNUSED_MASK})
            `CHK(clock_out_active, ~f[11])
            `CHK(brownout_reset_mode, enable_mode_t'(f[10:9]))
            `CHK(code_protect_on, ~f[7])
            `CHK(powerup_timer_on, ~f[5])
            `CHK(watchdog_mode, enable_mode_t'(f[4:3]))
            `CHK(oscillator_select, osc_source_t'(f[1:0]))
            wr(`OFS_PM_CONTROL, 32'h0, r);
            wr(`OFS_SOFT_ENABLES, {29'h0, i[1], 2'b11}, r);
            repeat (2) @(posedge aclk);
            `CHK(ext_reset_enabled, f[6])
            `CHK(pullup_on, f[6] | i[1])
            `CHK(brownout_active, mode_exp(f[10:9], i[0], 1'b1))
            `CHK(watchdog_active, mode_exp(f[4:3], i[0], 1'b1))
            fuse_word <= ~f;
            rd(`OFS_CONFIG_WORD, d, r);
            `CHK(d[13:0], f | `CFG_UNUSED_MASK)
            pa = 15'($random(seed));
            e = pm_word(pa, i[0]);
            wr(`OFS_PM_ADDR_LOW, {24'h0, pa[7:0]}, r);
            wr(`OFS_PM_ADDR_HIGH, {25'h0, pa[14:8]}, r);
            c0 = disc;
            wr(`OFS_PM_CONTROL, {25'h0, i[0], 5'h0, 1'b1}, r);
            // Two idle slots after the strobe
            repeat (2) @(posedge aclk);
            `CHK(disc - c0, 1)
            `CHK(read_busy, 1'b0)
            `CHK(progmem_addr, pa)
            rd(`OFS_PM_DATA_LOW, d, r);
            `CHK(d[7:0], e[7:0])
            rd(`OFS_PM_DATA_HIGH, d, r);
            `CHK(d[5:0], e[13:8])
            wr(`OFS_PM_ADDR_LOW, 32'h0, r);
            rd(`OFS_PM_DATA_LOW, d, r);
            `CHK(d[7:0], e[7:0])
            wr(`OFS_PM_DATA_LOW, 32'h5a, r);
            rd(`OFS_PM_DATA_LOW, d, r);
            `CHK(d[7:0], 8'h5a)
            $display("fuse test %0d done", i);
        end
        wr(`OFS_STATUS, 32'h0, r);
        rd(`OFS_STATUS, d, r);
        `CHK(d[1], 1'b1)
        wr(`OFS_ERASE_KEY, `ERASE_KEY_VALUE, r);
        rd(`OFS_STATUS, d, r);
        `CHK(d[1], 1'b0)
        rd(`OFS_CONFIG_WORD, d, r);
        `CHK(d[13:0], `CFG_BLANK)
        rd(8'h40, d, r);
        `CHK(r, `RESP_SLVERR)
        $display("erase test done");
        wrap_up();
    end
endmodule // tb
